//--- bench/ewp_guard_ctrl_properties.sv
// port assertions for the eeprom guard control block
`timescale 1ns/100ps
module ewp_guard_props (
    input wire logic               clk,
    input wire logic               rst_b,
    input wire logic               awready,
    input wire logic               wready,
    input wire logic               bvalid,
    input wire logic               bready,
    input wire logic [1:0]         bresp,
    input wire logic               arvalid,
    input wire logic               arready,
    input wire logic [7:0]         araddr,
    input wire logic               rvalid,
    input wire logic               rready,
    input wire logic [31:0]        rdata,
    input wire logic [1:0]         rresp,
    input wire ewp_pkg::ewp_pins_s pins,
    input wire logic               dout,
    input wire logic               dout_oe_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sel_release_a: assert property (!pins.sel [*4] |-> dout_oe_b)
        else $error("output driven while deselected");
    ready_hold_a: assert property ((pins.sel && !pins.sclk) [*4]
        ##0 (!dout_oe_b && dout) |=> !dout_oe_b && dout)
        else $error("ready dropped without start or deselect");
    busy_hold_a: assert property (pins.sel [*4] ##0 (!dout_oe_b && !dout) |=> !dout_oe_b)
        else $error("output released while selected");
    drive_sel_a: assert property ($fell(dout_oe_b) |-> $past(pins.sel, 3))
        else $error("output driven without select");
    wr_pair_a: assert property (awready |-> wready)
        else $error("write channels taken apart");
    wr_resp_a: assert property (awready |=> bvalid)
        else $error("write response late");
    resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response not held");
    rd_resp_a: assert property (arready |=> rvalid)
        else $error("read data late");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)
        && $stable(rresp))
        else $error("read data not held");
    unmapped_rd_a: assert property (arvalid && arready && araddr > 8'h04
        |=> rresp == ewp_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule : ewp_guard_props

bind ewp_guard_ctrl ewp_guard_props ewp_guard_props_i (.*);

//--- bench/ewp_host_model.sv
// host controller model driving select, serial clock, data and guard pins
`timescale 1ns/100ps
module ewp_host_model (
    input  wire logic          clk,
    input  wire logic          dout,
    input  wire logic          dout_oe_b,
    output ewp_pkg::ewp_pins_s pins
);
    initial pins = '0;

    task automatic tick(input logic b);
        pins.din = b;
        #160 pins.sclk = 1'b1;
        #160 pins.sclk = 1'b0;
    endtask : tick

    // start bit, opcode and address; pins held through the frame
    task automatic instr(input logic [7:0] code, input logic g, input logic p, input logic hold);
        // pin changes kept off the sampling edge
        @(negedge clk);
        pins.guard = g;
        pins.permit = p;
        #160 pins.sel = 1'b1;
        #160 tick(1'b1);
        for (int i = 7; i >= 0; i--) tick(code[i]);
        if (!hold) pins.sel = 1'b0;
        pins.din = 1'b0;
        #320;
    endtask : instr

    task automatic shift_in(output logic [7:0] v);
        @(negedge clk);
        for (int i = 7; i >= 0; i--)
        begin
            v[i] = dout;
            pins.sclk = 1'b1;
            #160 pins.sclk = 1'b0;
            #160;
        end
        pins.sel = 1'b0;
        #320;
    endtask : shift_in

    task automatic poll(input int wait_ns, output logic busy, output logic rdy);
        @(negedge clk);
        pins.sel = 1'b1;
        #240 busy = (dout_oe_b === 1'b0 && dout === 1'b0);
        #(wait_ns) rdy = (dout_oe_b === 1'b0 && dout === 1'b1);
        pins.sel = 1'b0;
        #320;
    endtask : poll

    // data words after a held frame, then deselect to start the store
    task automatic send_words(input int n);
        @(negedge clk);
        for (int i = 0; i < n * 16; i++) tick(i[2]);
        pins.sel = 1'b0;
        #320;
    endtask : send_words
endmodule : ewp_host_model

//--- bench/testbench.sv
// self-checking bench for the eeprom guard control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
module testbench;
    localparam logic [7:0] EN_CODE = {ewp_pkg::OP_MISC, ewp_pkg::SUB_UNLOCK, 4'h0};
    logic               clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid, dout, dout_oe_b;
    logic [7:0]         awaddr, araddr;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp;
    ewp_pkg::ewp_pins_s pins;
    logic [5:0]         eb;
    logic               ef;
    int                 err_count, compares, cyc, prog_ns;
    int                 seed = 32'h7da0_594d;

    ewp_guard_ctrl ewp_guard_ctrl_i (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pins(pins), .dout(dout), .dout_oe_b(dout_oe_b));
    ewp_host_model ewp_host_model_i (.clk(clk), .dout(dout), .dout_oe_b(dout_oe_b),
        .pins(pins));

    always #20 clk = ~clk;

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    function automatic logic [7:0] read_word(input logic [5:0] b, input logic f);
        return {1'b0, b, f};
    endfunction : read_word

    function automatic logic [6:0] guard_next(input logic [7:0] c, input logic [5:0] b,
                                              input logic f);
        if (c[7:6] == ewp_pkg::OP_WRITE)
            return {c[5:0], 1'b0};
        if (c[7:6] == ewp_pkg::OP_GROUP)
            return {ewp_pkg::BOUND_CLEARED, 1'b1};
        return {b, f};
    endfunction : guard_next

    function automatic logic store_ok(input logic [7:0] c, input int n);
        store_ok = (c[7:6] != ewp_pkg::OP_MISC) || ef;
        for (int i = 0; i < n; i++)
            if (!ef && {c[5:2], 2'(c[1:0] + i)} >= eb)
                store_ok = 1'b0;
    endfunction : store_ok

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic chk_status(input logic [5:0] b, input logic f);
        logic [31:0] d;
        logic [1:0]  r;
        rd(ewp_pkg::OFS_STATUS, d, r);
        `CHK("boundary", b, d[5:0])
        `CHK("flag", f, d[ewp_pkg::ST_FLAG_BIT])
    endtask : chk_status

    task automatic gread(input logic [5:0] b, input logic f);
        logic [7:0] v;
        ewp_host_model_i.instr({ewp_pkg::OP_READ, 6'h00}, 1'b1, 1'b1, 1'b1);
        ewp_host_model_i.shift_in(v);
        `CHK("guard read", read_word(b, f), v)
    endtask : gread

    task automatic gop(input logic [7:0] code, input logic un, input logic p, input logic ok);
        logic bsy;
        logic rdy;
        ewp_host_model_i.instr(EN_CODE, 1'b0, 1'b1, 1'b0);
        ewp_host_model_i.instr(EN_CODE, un, 1'b1, 1'b0);
        chk_status(eb, ef);
        ewp_host_model_i.instr(code, 1'b1, p, 1'b0);
        ewp_host_model_i.poll(prog_ns, bsy, rdy);
        `CHK("busy shown", ok, bsy)
        `CHK("ready shown", ok, rdy)
        if (ok)
            {eb, ef} = guard_next(code, eb, ef);
        chk_status(eb, ef);
    endtask : gop

    task automatic store(input logic [7:0] code, input int n);
        logic bsy;
        logic rdy;
        logic ok;
        ok = store_ok(code, n);
        ewp_host_model_i.instr(code, 1'b0, 1'b1, 1'b1);
        ewp_host_model_i.send_words(n);
        ewp_host_model_i.poll(prog_ns, bsy, rdy);
        `CHK("store busy", ok, bsy)
        `CHK("store ready", ok, rdy)
    endtask : store

    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [5:0]  a;
        int          n;
        {clk, rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, cyc, err_count, compares} = '0;
        wstrb = 4'hf;
        eb = ewp_pkg::RST_BOUND;
        ef = ewp_pkg::RST_FLAG;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd(ewp_pkg::OFS_CTRL, d, r);
        `CHK("cycle reset", ewp_pkg::RST_PROG_CYC, d[15:0])
        chk_status(eb, ef);
        rd(8'h08, d, r);
        `CHK("unmapped read", ewp_pkg::RESP_SLVERR, r)
        wr(8'h0c, 32'h0000_0000, r);
        `CHK("unmapped write", ewp_pkg::RESP_SLVERR, r)
        n = 30 + ($unsigned($random(seed)) % 16);
        wr(ewp_pkg::OFS_CTRL, 32'(n), r);
        `CHK("ctrl write", ewp_pkg::RESP_OKAY, r)
        rd(ewp_pkg::OFS_CTRL, d, r);
        `CHK("ctrl readback", 16'(n), d[15:0])
        prog_ns = n * 40 + 400;
        $display("test register access done");
        gop({ewp_pkg::OP_WRITE, 6'h05}, 1'b0, 1'b1, 1'b0);
        gop({ewp_pkg::OP_WRITE, 6'h05}, 1'b1, 1'b0, 1'b0);
        $display("test refused guard ops done");
        for (int i = 0; i < 6; i++)
        begin
            a = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : 6'($random(seed));
            gop({ewp_pkg::OP_WRITE, a}, 1'b1, 1'b1, 1'b1);
            eb = a;
            ef = 1'b0;
            chk_status(eb, ef);
            gread(eb, ef);
        end
        $display("test guard write done");
        gop({ewp_pkg::OP_GROUP, ewp_pkg::ADR_CLEAR}, 1'b1, 1'b1, 1'b1);
        eb = ewp_pkg::BOUND_CLEARED;
        ef = 1'b1;
        gread(eb, ef);
        $display("test guard clear done");
        gop({ewp_pkg::OP_WRITE, 6'h20}, 1'b1, 1'b1, 1'b1);
        eb = 6'h20;
        ef = 1'b0;
        gop({ewp_pkg::OP_MISC, ewp_pkg::ADR_LOCK}, 1'b1, 1'b1, 1'b1);
        gop({ewp_pkg::OP_WRITE, 6'h10}, 1'b1, 1'b1, 1'b0);
        gop({ewp_pkg::OP_GROUP, ewp_pkg::ADR_CLEAR}, 1'b1, 1'b1, 1'b0);
        gread(eb, ef);
        $display("test guard lock done");
        store({ewp_pkg::OP_WRITE, 6'h05}, 1);
        store({ewp_pkg::OP_WRITE, 6'h30}, 1);
        store({ewp_pkg::OP_GROUP, 6'h1e}, 4);
        store({ewp_pkg::OP_GROUP, 6'h3e}, 2);
        store({ewp_pkg::OP_MISC, ewp_pkg::SUB_FILL, 4'h0}, 1);
        $display("test guarded store done");
        complete_run();
    end
endmodule : testbench

//--- design/ewp_guard_ctrl.sv
// serial eeprom write-guard control with axi4-lite status and timing access
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module ewp_guard_ctrl (
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    input  wire logic [ewp_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [ewp_pkg::DATA_W-1:0]   wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    input  wire logic [ewp_pkg::ADDR_W-1:0]   araddr,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [ewp_pkg::DATA_W-1:0]        rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    input  wire ewp_pkg::ewp_pins_s           pins,
    output logic                              dout,
    output logic                              dout_oe_b
);
    ewp_pkg::ewp_pins_s   pin_s;
    ewp_pkg::ewp_state_e  st_q,    st_d;
    ewp_pkg::ewp_pend_e   pend_q,  pend_d;
    logic                 sel_p_q, sck_p_q;
    logic [7:0]           cmd_q,   cmd_d;
    logic [4:0]           bit_q,   bit_d;
    logic [2:0]           words_q, words_d;
    logic [2:0]           wmax_q,  wmax_d;
    logic                 bad_q,   bad_d;
    logic [7:0]           out_q,   out_d;
    logic [5:0]           bound_q, bound_d;
    logic                 flag_q,  flag_d;
    logic                 lock_q,  lock_d;
    logic                 wen_q,   wen_d;
    logic                 unl_q,   unl_d;
    logic                 rb_q,    rb_d;
    logic [15:0]          prog_q,  prog_d;
    logic [15:0]          cyc_q,   cyc_d;
    logic                 dout_d,  oe_b_d;
    logic                 awr_d,   bv_d,   arr_d,  rv_d;
    logic [1:0]           br_d,    rr_d;
    logic [31:0]          rd_d;
    logic                 rise,    sel_fall, busy;
    logic [7:0]           full;
    logic [5:0]           waddr;
    logic                 go;

    ewp_sync2 #(.W(5)) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (pins),
        .q     (pin_s)
    );

    function automatic logic guarded(input logic [5:0] a, input logic f,
                                     input logic [5:0] b);
        guarded = !f && (a >= b);
    endfunction : guarded

    always_comb
    begin
        rise     = pin_s.sclk && !sck_p_q;
        sel_fall = !pin_s.sel && sel_p_q;
        busy     = prog_q != 16'h0000;
        full     = {cmd_q[6:0], pin_s.din};
        waddr    = {cmd_q[5:2], cmd_q[1:0] + words_q[1:0]};
        st_d     = st_q;
        pend_d   = pend_q;
        cmd_d    = cmd_q;
        bit_d    = bit_q;
        words_d  = words_q;
        wmax_d   = wmax_q;
        bad_d    = bad_q;
        out_d    = out_q;
        bound_d  = bound_q;
        flag_d   = flag_q;
        lock_d   = lock_q;
        wen_d    = wen_q;
        unl_d    = unl_q;
        rb_d     = rb_q;
        go       = 1'b0;
        prog_d   = busy ? prog_q - 16'h0001 : prog_q;
        unique case (st_q)
            ewp_pkg::S_IDLE:
            begin
                if (pin_s.sel && !busy)
                    st_d = ewp_pkg::S_START;
            end
            ewp_pkg::S_START:
            begin
                if (rise && pin_s.din)
                begin
                    st_d   = ewp_pkg::S_CMD;
                    bit_d  = 5'h00;
                    rb_d   = 1'b0;
                    pend_d = ewp_pkg::P_NONE;
                end
            end
            ewp_pkg::S_CMD:
            begin
                if (rise)
                begin
                    cmd_d = full;
                    bit_d = bit_q + 5'h01;
                    if (bit_q == 5'(ewp_pkg::CMD_BITS - 1))
                    begin
                        st_d    = ewp_pkg::S_SKIP;
                        bit_d   = 5'h00;
                        words_d = 3'h0;
                        bad_d   = 1'b0;
                        unl_d   = 1'b0;
                        if (pin_s.guard)
                        begin
                            unique case (full[7:6])
                                ewp_pkg::OP_READ:
                                begin
                                    st_d  = ewp_pkg::S_READ;
                                    out_d = {1'b0, bound_q, flag_q};
                                end
                                ewp_pkg::OP_WRITE:
                                    if (unl_q)
                                        pend_d = ewp_pkg::P_GWR;
                                ewp_pkg::OP_GROUP:
                                    if (unl_q && full[5:0] == ewp_pkg::ADR_CLEAR)
                                        pend_d = ewp_pkg::P_GCLR;
                                ewp_pkg::OP_MISC:
                                begin
                                    if (full[5:4] == ewp_pkg::SUB_UNLOCK)
                                        unl_d = wen_q && pin_s.permit;
                                    else if (unl_q && full[5:0] == ewp_pkg::ADR_LOCK)
                                        pend_d = ewp_pkg::P_GLOCK;
                                end
                            endcase
                        end
                        else
                        begin
                            unique case (full[7:6])
                                ewp_pkg::OP_READ:
                                    st_d = ewp_pkg::S_SKIP;
                                ewp_pkg::OP_WRITE:
                                begin
                                    st_d   = ewp_pkg::S_DATA;
                                    wmax_d = 3'h1;
                                    pend_d = ewp_pkg::P_STORE;
                                end
                                ewp_pkg::OP_GROUP:
                                begin
                                    st_d   = ewp_pkg::S_DATA;
                                    wmax_d = 3'(ewp_pkg::GROUP_MAX);
                                    pend_d = ewp_pkg::P_STORE;
                                end
                                ewp_pkg::OP_MISC:
                                begin
                                    if (full[5:4] == ewp_pkg::SUB_FILL)
                                    begin
                                        st_d   = ewp_pkg::S_DATA;
                                        wmax_d = 3'h1;
                                        pend_d = ewp_pkg::P_FILL;
                                    end
                                    else if (full[5:4] == ewp_pkg::SUB_UNLOCK)
                                        wen_d = pin_s.permit;
                                    else if (full[5:4] == ewp_pkg::SUB_OFF)
                                        wen_d = 1'b0;
                                end
                            endcase
                        end
                    end
                end
            end
            ewp_pkg::S_DATA:
            begin
                if (rise && words_q < wmax_q)
                begin
                    bit_d = bit_q + 5'h01;
                    if (bit_q == 5'(ewp_pkg::WORD_BITS - 1))
                    begin
                        bit_d   = 5'h00;
                        words_d = words_q + 3'h1;
                        if (guarded(waddr, flag_q, bound_q))
                            bad_d = 1'b1;
                    end
                end
            end
            ewp_pkg::S_READ:
            begin
                if (rise)
                    out_d = {out_q[6:0], 1'b0};
            end
            ewp_pkg::S_SKIP:
            begin
                st_d = ewp_pkg::S_SKIP;
            end
        endcase
        if (!pin_s.sel)
        begin
            st_d = ewp_pkg::S_IDLE;
            if (!busy)
                rb_d = 1'b0;
        end
        if (sel_fall && !busy && (st_q == ewp_pkg::S_SKIP || st_q == ewp_pkg::S_DATA))
        begin
            unique case (pend_q)
                ewp_pkg::P_STORE:
                    go = wen_q && pin_s.permit && words_q != 3'h0 && !bad_q;
                ewp_pkg::P_FILL:
                    go = wen_q && pin_s.permit && words_q != 3'h0 && flag_q;
                ewp_pkg::P_GWR, ewp_pkg::P_GCLR, ewp_pkg::P_GLOCK:
                    go = wen_q && pin_s.permit && pin_s.guard && !lock_q;
                default:
                    go = 1'b0;
            endcase
            if (go)
            begin
                prog_d = (cyc_q == 16'h0000) ? 16'h0001 : cyc_q;
                rb_d   = 1'b1;
                if (pend_q == ewp_pkg::P_GWR)
                begin
                    bound_d = cmd_q[5:0];
                    flag_d  = 1'b0;
                end
                if (pend_q == ewp_pkg::P_GCLR)
                begin
                    bound_d = ewp_pkg::BOUND_CLEARED;
                    flag_d  = 1'b1;
                end
                if (pend_q == ewp_pkg::P_GLOCK)
                    lock_d = 1'b1;
            end
            pend_d = ewp_pkg::P_NONE;
        end
        if (st_q == ewp_pkg::S_READ && pin_s.sel)
        begin
            dout_d = out_q[7];
            oe_b_d = 1'b0;
        end
        else if (rb_q && pin_s.sel)
        begin
            dout_d = !busy;
            oe_b_d = 1'b0;
        end
        else
        begin
            dout_d = 1'b1;
            oe_b_d = 1'b1;
        end
    end

    always_comb
    begin
        cyc_d = cyc_q;
        awr_d = awvalid && wvalid && !awready && !bvalid;
        bv_d  = bvalid && !bready;
        br_d  = bresp;
        if (awready)
        begin
            bv_d = 1'b1;
            br_d = ewp_pkg::RESP_OKAY;
            if (awaddr == ewp_pkg::OFS_CTRL)
            begin
                if (wstrb[0])
                    cyc_d[7:0] = wdata[ewp_pkg::CTRL_CYC_LSB +: 8];
                if (wstrb[1])
                    cyc_d[15:8] = wdata[ewp_pkg::CTRL_CYC_LSB + 8 +: 8];
            end
            else if (awaddr != ewp_pkg::OFS_STATUS)
                br_d = ewp_pkg::RESP_SLVERR;
        end
        arr_d = arvalid && !arready && !rvalid;
        rv_d  = rvalid && !rready;
        rr_d  = rresp;
        rd_d  = rdata;
        if (arready)
        begin
            rv_d = 1'b1;
            rr_d = ewp_pkg::RESP_OKAY;
            rd_d = 32'h0000_0000;
            if (araddr == ewp_pkg::OFS_CTRL)
                rd_d[ewp_pkg::CTRL_CYC_LSB +: ewp_pkg::CTRL_CYC_W] = cyc_q;
            else if (araddr == ewp_pkg::OFS_STATUS)
            begin
                rd_d[ewp_pkg::ST_BOUND_LSB +: ewp_pkg::WORD_A_W] = bound_q;
                rd_d[ewp_pkg::ST_FLAG_BIT]   = flag_q;
                rd_d[ewp_pkg::ST_BUSY_BIT]   = busy;
                rd_d[ewp_pkg::ST_WEN_BIT]    = wen_q;
                rd_d[ewp_pkg::ST_UNLOCK_BIT] = unl_q;
                rd_d[ewp_pkg::ST_READY_BIT]  = rb_q;
            end
            else
                rr_d = ewp_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q      <= ewp_pkg::S_IDLE;
            pend_q    <= ewp_pkg::P_NONE;
            sel_p_q   <= 1'b0;
            sck_p_q   <= 1'b0;
            cmd_q     <= 8'h00;
            bit_q     <= 5'h00;
            words_q   <= 3'h0;
            wmax_q    <= 3'h0;
            bad_q     <= 1'b0;
            out_q     <= 8'h00;
            bound_q   <= ewp_pkg::RST_BOUND;
            flag_q    <= ewp_pkg::RST_FLAG;
            lock_q    <= 1'b0;
            wen_q     <= 1'b0;
            unl_q     <= 1'b0;
            rb_q      <= 1'b0;
            prog_q    <= 16'h0000;
            cyc_q     <= ewp_pkg::RST_PROG_CYC;
            dout      <= 1'b1;
            dout_oe_b <= 1'b1;
            awready   <= 1'b0;
            wready    <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= ewp_pkg::RESP_OKAY;
            arready   <= 1'b0;
            rvalid    <= 1'b0;
            rresp     <= ewp_pkg::RESP_OKAY;
            rdata     <= 32'h0000_0000;
        end
        else
        begin
            st_q      <= st_d;
            pend_q    <= pend_d;
            sel_p_q   <= pin_s.sel;
            sck_p_q   <= pin_s.sclk;
            cmd_q     <= cmd_d;
            bit_q     <= bit_d;
            words_q   <= words_d;
            wmax_q    <= wmax_d;
            bad_q     <= bad_d;
            out_q     <= out_d;
            bound_q   <= bound_d;
            flag_q    <= flag_d;
            lock_q    <= lock_d;
            wen_q     <= wen_d;
            unl_q     <= unl_d;
            rb_q      <= rb_d;
            prog_q    <= prog_d;
            cyc_q     <= cyc_d;
            dout      <= dout_d;
            dout_oe_b <= oe_b_d;
            awready   <= awr_d;
            wready    <= awr_d;
            bvalid    <= bv_d;
            bresp     <= br_d;
            arready   <= arr_d;
            rvalid    <= rv_d;
            rresp     <= rr_d;
            rdata     <= rd_d;
        end
    end
endmodule : ewp_guard_ctrl

//--- design/ewp_pkg.sv
// constants, types and state codes for the eeprom guard control block
package ewp_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam int          WORD_A_W       = 6;
    localparam int          CMD_BITS       = 8;
    localparam int          WORD_BITS      = 16;
    localparam int          GROUP_MAX      = 4;
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STATUS     = 8'h04;
    localparam int          CTRL_CYC_LSB   = 0;
    localparam int          CTRL_CYC_W     = 16;
    localparam int          ST_BOUND_LSB   = 0;
    localparam int          ST_FLAG_BIT    = 8;
    localparam int          ST_BUSY_BIT    = 9;
    localparam int          ST_WEN_BIT     = 10;
    localparam int          ST_UNLOCK_BIT  = 11;
    localparam int          ST_READY_BIT   = 12;
    localparam logic [15:0] RST_PROG_CYC   = 16'h0064;
    localparam logic [5:0]  RST_BOUND      = 6'h3f;
    localparam logic        RST_FLAG       = 1'b1;
    localparam logic [5:0]  BOUND_CLEARED  = 6'h3f;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam logic [1:0]  OP_WRITE       = 2'h1;
    localparam logic [1:0]  OP_GROUP       = 2'h3;
    localparam logic [1:0]  OP_MISC        = 2'h0;
    localparam logic [1:0]  SUB_FILL       = 2'h1;
    localparam logic [1:0]  SUB_UNLOCK     = 2'h3;
    localparam logic [1:0]  SUB_OFF        = 2'h0;
    localparam logic [5:0]  ADR_CLEAR      = 6'h3f;
    localparam logic [5:0]  ADR_LOCK       = 6'h00;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic sel;
        logic sclk;
        logic din;
        logic guard;
        logic permit;
    } ewp_pins_s;

    typedef enum logic [5:0] {
        S_IDLE  = 6'h01,
        S_START = 6'h02,
        S_CMD   = 6'h04,
        S_DATA  = 6'h08,
        S_READ  = 6'h10,
        S_SKIP  = 6'h20
    } ewp_state_e;

    typedef enum logic [5:0] {
        P_NONE  = 6'h01,
        P_STORE = 6'h02,
        P_FILL  = 6'h04,
        P_GWR   = 6'h08,
        P_GCLR  = 6'h10,
        P_GLOCK = 6'h20
    } ewp_pend_e;
endpackage : ewp_pkg

//--- design/ewp_sync2.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module ewp_sync2 #(
    parameter int W = 5
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : ewp_sync2
